// [hdl/mic_consts.vh]
// Constants of the interrupt controller: offsets, fields, resets, timing
`ifndef MIC_CONSTS_VH
`define MIC_CONSTS_VH
// Register word offsets (one Avalon address per register)
`define MIC_OFS_CTRL      4'h0
`define MIC_OFS_OPTION    4'h1
`define MIC_OFS_PFLAG     4'h2
`define MIC_OFS_PEN       4'h3
`define MIC_OFS_CORE      4'h4
`define MIC_OFS_TIMER     4'h5
`define MIC_OFS_ISTAT     4'h6
`define MIC_OFS_IMASK     4'h7
// Control register fields
`define MIC_CTL_PORT_FLAG 0
`define MIC_CTL_EXT_FLAG  1
`define MIC_CTL_TMR_FLAG  2
`define MIC_CTL_PORT_EN   3
`define MIC_CTL_EXT_EN    4
`define MIC_CTL_TMR_EN    5
`define MIC_CTL_PGRP_EN   6
`define MIC_CTL_GIE       7
// Option register field
`define MIC_OPT_EDGE      6
// Reset values
`define MIC_CTRL_RST      8'h00
`define MIC_OPTION_RST    8'hFF
`define MIC_PERIPH_RST    8'h00
// Vector address
`define MIC_VECTOR        13'h0004
// Latency: instruction cycle in core clocks and cycles of latency
`define MIC_ICYC_CLKS     4
`define MIC_LAT_MIN_ICYC  3
// Clocks after reset before the pin edge detectors are armed
`define MIC_SETTLE_CLKS   3'h5
// Status event bits
`define MIC_EV_VECTOR     0
`define MIC_EV_WAKE       1
`define MIC_EV_RETURN     2
`endif

// [hdl/mic_sync.v]
// Three-flop pin synchroniser with agreement of the last two stages
`timescale 1ns/1ns
`default_nettype none
module mic_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         arst_n,
    input  wire [W-1:0] pin,
    output reg  [W-1:0] level_q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    // Stage one feeds stage two only; level moves once two and three agree
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q    <= {W{1'b0}};
            s2_q    <= {W{1'b0}};
            s3_q    <= {W{1'b0}};
            level_q <= {W{1'b0}};
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
        end
    end
endmodule
`default_nettype wire

// [hdl/mic_latency.v]
// Latency pipe: holds a request for a fixed number of clocks
`timescale 1ns/1ns
`default_nettype none
module mic_latency #(
    parameter DEPTH = 12
) (
    input  wire clk,
    input  wire arst_n,
    input  wire flush,
    input  wire req_in,
    output wire req_out
);
    reg [DEPTH-1:0] pipe_q;
    // Delay line cleared on flush so a stale request never vectors twice
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pipe_q <= {DEPTH{1'b0}};
        end else if (flush) begin
            pipe_q <= {DEPTH{1'b0}};
        end else begin
            pipe_q <= {pipe_q[DEPTH-2:0], req_in};
        end
    end
    assign req_out = pipe_q[DEPTH-1];
endmodule
`default_nettype wire

// [hdl/mic_irq_ctrl.v]
// Interrupt controller of the microcontroller, with an Avalon-MM slave
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "mic_consts.vh"
module mic_irq_ctrl #(
    parameter NPERIPH = 8,
    parameter PCW     = 13
) (
    input  wire               clk,
    input  wire               arst_n,
    input  wire [3:0]         avs_address,
    input  wire               avs_read,
    input  wire               avs_write,
    input  wire [31:0]        avs_writedata,
    output reg  [31:0]        avs_readdata,
    output reg                avs_waitrequest,
    input  wire               ext_irq_pin,
    input  wire [3:0]         upper_port_pins,
    input  wire               timer_tick,
    input  wire [NPERIPH-1:0] periph_event,
    input  wire               core_sleep,
    input  wire               return_from_irq_instr,
    input  wire [PCW-1:0]     core_next_pc,
    output reg                core_vector_q,
    output reg  [PCW-1:0]     core_pc_load_q,
    output reg                stack_push_q,
    output reg  [PCW-1:0]     stack_data_q,
    output reg                core_wake_q,
    output reg                irq_q
);
    localparam LAT_CLKS = `MIC_ICYC_CLKS * `MIC_LAT_MIN_ICYC;
    localparam ST_RUN   = 2'd0;
    localparam ST_SLEEP = 2'd1;
    localparam ST_WAIT  = 2'd2;

    reg [7:0]         ctrl_q;
    reg [7:0]         option_q;
    reg [NPERIPH-1:0] pflag_q;
    reg [NPERIPH-1:0] pen_q;
    reg [7:0]         timer_zero_count_q;
    reg [2:0]         istat_q;
    reg [2:0]         imask_q;
    reg [1:0]         state_q;
    reg               ext_prev_q;
    reg [3:0]         port_prev_q;
    reg               ack_q;

    wire              ext_lvl;
    wire [3:0]        port_lvl;
    wire              lat_req;

    // Pins cross into the clock domain through three flops
    mic_sync #(.W(1)) u_ext_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .pin     (ext_irq_pin),
        .level_q (ext_lvl)
    );
    mic_sync #(.W(4)) u_port_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .pin     (upper_port_pins),
        .level_q (port_lvl)
    );

    // Edge detectors stay blind until the synchronisers hold the real pin;
    // a pin idling high would otherwise fake an edge right after reset
    reg [2:0]         settle_q;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            settle_q <= 3'h0;
        end else if (settle_q != `MIC_SETTLE_CLKS) begin
            settle_q <= settle_q + 3'h1;
        end
    end
    wire armed      = (settle_q == `MIC_SETTLE_CLKS);

    // Event detection
    wire edge_sel   = option_q[`MIC_OPT_EDGE];
    wire ext_ev     = armed & (edge_sel ? (ext_lvl & ~ext_prev_q)
                                        : (~ext_lvl & ext_prev_q));

    // One change detector per upper port pin; any of them raises the flag
    wire [3:0]        port_chg;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_port_chg
            assign port_chg[gi] = armed & (port_lvl[gi] ^ port_prev_q[gi]);
        end
    endgenerate
    wire port_ev    = |port_chg;
    wire tmr_ev     = timer_tick & (timer_zero_count_q == 8'hFF);

    // Register bus decode, single wait state
    wire bus_req    = (avs_read | avs_write) & ~ack_q;
    wire wr         = avs_write & ack_q;
    wire wr_ctrl    = wr & (avs_address == `MIC_OFS_CTRL);
    wire wr_opt     = wr & (avs_address == `MIC_OFS_OPTION);
    wire wr_pflag   = wr & (avs_address == `MIC_OFS_PFLAG);
    wire wr_pen     = wr & (avs_address == `MIC_OFS_PEN);
    wire wr_tmr     = wr & (avs_address == `MIC_OFS_TIMER);
    wire wr_istat   = wr & (avs_address == `MIC_OFS_ISTAT);
    wire wr_imask   = wr & (avs_address == `MIC_OFS_IMASK);

    // Request: global enable AND any enabled pair; peripherals group-gated
    wire periph_any = ctrl_q[`MIC_CTL_PGRP_EN] & |(pflag_q & pen_q);
    wire pair_any   = (ctrl_q[`MIC_CTL_EXT_FLAG]  & ctrl_q[`MIC_CTL_EXT_EN])
                    | (ctrl_q[`MIC_CTL_TMR_FLAG]  & ctrl_q[`MIC_CTL_TMR_EN])
                    | (ctrl_q[`MIC_CTL_PORT_FLAG] & ctrl_q[`MIC_CTL_PORT_EN])
                    | periph_any;
    wire irq_req    = ctrl_q[`MIC_CTL_GIE] & pair_any;
    // Wake ignores the global enable; decided later whether to vector
    wire wake_req   = pair_any;

    // Fixed latency pipe so vectoring lands three instruction cycles later
    mic_latency #(.DEPTH(LAT_CLKS)) u_lat (
        .clk     (clk),
        .arst_n  (arst_n),
        .flush   (~irq_req | core_vector_q),
        .req_in  (irq_req),
        .req_out (lat_req)
    );

    wire do_vector  = (state_q == ST_RUN) & lat_req & irq_req & ~core_vector_q;
    // Wake entry vectors only with the global enable still set
    wire wake_vec   = (state_q == ST_WAIT) & ctrl_q[`MIC_CTL_GIE];
    wire wake_now   = (state_q == ST_SLEEP) & wake_req;

    // Flag next values: hardware set wins over software clear
    reg [7:0]         ctrl_d;
    always @* begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = avs_writedata[7:0];
        end
        if (ext_ev) begin
            ctrl_d[`MIC_CTL_EXT_FLAG] = 1'b1;
        end
        if (tmr_ev) begin
            ctrl_d[`MIC_CTL_TMR_FLAG] = 1'b1;
        end
        if (port_ev) begin
            ctrl_d[`MIC_CTL_PORT_FLAG] = 1'b1;
        end
        // Both entry paths close the gate, or the still-set flag re-enters
        if (do_vector | wake_vec) begin
            ctrl_d[`MIC_CTL_GIE] = 1'b0;
        end else if (return_from_irq_instr) begin
            ctrl_d[`MIC_CTL_GIE] = 1'b1;
        end
    end

    // Peripheral flags, one per source; an event beats a bus write
    wire [NPERIPH-1:0] pflag_d;
    genvar gp;
    generate
        for (gp = 0; gp < NPERIPH; gp = gp + 1) begin : g_pflag
            assign pflag_d[gp] = periph_event[gp]
                               | (wr_pflag ? avs_writedata[gp] : pflag_q[gp]);
        end
    endgenerate

    // Control, option and peripheral registers
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q   <= `MIC_CTRL_RST;
            option_q <= `MIC_OPTION_RST;
            pflag_q  <= {NPERIPH{1'b0}};
            pen_q    <= {NPERIPH{1'b0}};
        end else begin
            ctrl_q  <= ctrl_d;
            pflag_q <= pflag_d;
            if (wr_opt) begin
                option_q <= avs_writedata[7:0];
            end
            if (wr_pen) begin
                pen_q <= avs_writedata[NPERIPH-1:0];
            end
        end
    end

    // Timer zero count with FFh to 00h rollover
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_zero_count_q <= 8'h00;
        end else if (wr_tmr) begin
            timer_zero_count_q <= avs_writedata[7:0];
        end else if (timer_tick) begin
            timer_zero_count_q <= timer_zero_count_q + 8'h01;
        end
    end

    // Edge history of the synchronised pins
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_prev_q  <= 1'b0;
            port_prev_q <= 4'h0;
        end else begin
            ext_prev_q  <= ext_lvl;
            port_prev_q <= port_lvl;
        end
    end

    // Sleep state machine; after wake one cycle decides vector or continue
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q     <= ST_RUN;
            core_wake_q <= 1'b0;
        end else begin
            core_wake_q <= 1'b0;
            case (state_q)
                ST_RUN: begin
                    if (core_sleep) begin
                        state_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wake_now) begin
                        state_q     <= ST_WAIT;
                        core_wake_q <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    state_q <= ST_RUN;
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Vector: push only the return address, load the vector
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_vector_q  <= 1'b0;
            core_pc_load_q <= {PCW{1'b0}};
            stack_push_q   <= 1'b0;
            stack_data_q   <= {PCW{1'b0}};
        end else begin
            core_vector_q <= do_vector | wake_vec;
            stack_push_q  <= do_vector | wake_vec;
            if (do_vector | wake_vec) begin
                core_pc_load_q <= `MIC_VECTOR;
                stack_data_q   <= core_next_pc;
            end
        end
    end

    // Bus-visible interrupt status: sticky, write one to clear, set wins
    wire [2:0] ev_vec = {return_from_irq_instr, core_wake_q, core_vector_q};
    wire [2:0] istat_d;
    genvar gs;
    generate
        for (gs = 0; gs < 3; gs = gs + 1) begin : g_istat
            // An event in the clearing cycle survives, so none is lost
            assign istat_d[gs] = ev_vec[gs] | (istat_q[gs] & ~(wr_istat & avs_writedata[gs]));
        end
    endgenerate

    // Status and mask registers; the line follows the status ANDed with the mask
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            istat_q <= 3'h0;
            imask_q <= 3'h0;
            irq_q   <= 1'b0;
        end else begin
            istat_q <= istat_d;
            if (wr_imask) begin
                imask_q <= avs_writedata[2:0];
            end
            irq_q <= |(istat_q & imask_q);
        end
    end

    // Read multiplexer; registered below so read data comes from a flop
    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h0000_0000;
        case (avs_address)
            `MIC_OFS_CTRL:   rdata_d = {24'h000000, ctrl_q};
            `MIC_OFS_OPTION: rdata_d = {24'h000000, option_q};
            `MIC_OFS_PFLAG:  rdata_d = {{(32-NPERIPH){1'b0}}, pflag_q};
            `MIC_OFS_PEN:    rdata_d = {{(32-NPERIPH){1'b0}}, pen_q};
            `MIC_OFS_CORE:   rdata_d = {29'h0, state_q == ST_SLEEP, lat_req, irq_req};
            `MIC_OFS_TIMER:  rdata_d = {24'h000000, timer_zero_count_q};
            `MIC_OFS_ISTAT:  rdata_d = {29'h0, istat_q};
            `MIC_OFS_IMASK:  rdata_d = {29'h0, imask_q};
            default:         rdata_d = 32'h0000_0000;
        endcase
    end

    // Avalon slave: waitrequest high one cycle, answer on second edge
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q           <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            ack_q           <= bus_req;
            avs_waitrequest <= ~bus_req;
            if (bus_req & avs_read) begin
                avs_readdata <= rdata_d;
            end
        end
    end
endmodule
`default_nettype wire

// [test/mic_irq_ctrl_assertions.sv]
// Port checker of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "mic_consts.vh"
module mic_irq_ctrl_assertions #(
    parameter NPERIPH = 8,
    parameter PCW     = 13
) (
    input wire logic               clk,
    input wire logic               arst_n,
    input wire logic [3:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_writedata,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    input wire logic               ext_irq_pin,
    input wire logic [3:0]         upper_port_pins,
    input wire logic               timer_tick,
    input wire logic [NPERIPH-1:0] periph_event,
    input wire logic               core_sleep,
    input wire logic               return_from_irq_instr,
    input wire logic [PCW-1:0]     core_next_pc,
    input wire logic               core_vector_q,
    input wire logic [PCW-1:0]     core_pc_load_q,
    input wire logic               stack_push_q,
    input wire logic [PCW-1:0]     stack_data_q,
    input wire logic               core_wake_q,
    input wire logic               irq_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Pending access, and the vector step with its push
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_vec;
        core_vector_q && stack_push_q;
    endsequence
    AST_WAIT_ANS: assert property (s_req |-> ##[1:2] !avs_waitrequest)
        else $error("bus answer late");
    AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    AST_VEC_PC: assert property (core_vector_q |-> core_pc_load_q == `MIC_VECTOR)
        else $error("vector address wrong");
    AST_VEC_PUSH: assert property (core_vector_q |-> s_vec)
        else $error("vector without push");
    AST_PUSH_VEC: assert property (stack_push_q |-> core_vector_q)
        else $error("push without vector");
    AST_VEC_ONCE: assert property (s_vec |=> !core_vector_q)
        else $error("vector repeated");
    AST_WAKE_ONE: assert property (core_wake_q |=> !core_wake_q)
        else $error("wake pulse too long");
    AST_RST_CLEAR: assert property ($rose(arst_n) |-> !core_vector_q && !irq_q)
        else $error("outputs active after reset");
endmodule
bind mic_irq_ctrl mic_irq_ctrl_assertions #(.NPERIPH(NPERIPH), .PCW(PCW)) u_chk (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_irq_pin(ext_irq_pin),
    .upper_port_pins(upper_port_pins), .timer_tick(timer_tick), .periph_event(periph_event),
    .core_sleep(core_sleep), .return_from_irq_instr(return_from_irq_instr),
    .core_next_pc(core_next_pc), .core_vector_q(core_vector_q),
    .core_pc_load_q(core_pc_load_q), .stack_push_q(stack_push_q),
    .stack_data_q(stack_data_q), .core_wake_q(core_wake_q), .irq_q(irq_q));
`default_nettype wire

// [test/mic_core_model.sv]
// Behavioural processor core facing the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module mic_core_model #(
    parameter PCW    = 13,
    parameter RET_PC = 13'h0123
) (
    input wire logic           clk,
    input wire logic           arst_n,
    input wire logic           sleep_cmd,
    input wire logic           ret_cmd,
    input wire logic           core_vector_q,
    input wire logic [PCW-1:0] core_pc_load_q,
    input wire logic [PCW-1:0] stack_data_q,
    output logic               core_sleep,
    output logic               return_from_irq_instr,
    output logic [PCW-1:0]     core_next_pc,
    output logic [7:0]         vec_cnt
);
    logic [PCW-1:0] ret_q;
    // Jump on vector, return only when the routine says so
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            core_sleep <= 1'b0;
            return_from_irq_instr <= 1'b0;
            core_next_pc <= RET_PC;
            ret_q <= RET_PC;
            vec_cnt <= 8'h00;
        end else begin
            core_sleep <= sleep_cmd;
            return_from_irq_instr <= ret_cmd;
            if (core_vector_q) begin
                ret_q <= stack_data_q;
                core_next_pc <= core_pc_load_q;
                vec_cnt <= vec_cnt + 8'h01;
            end else if (ret_cmd) begin
                core_next_pc <= ret_q;
            end
        end
    end
endmodule
`default_nettype wire

// [test/mic_irq_ctrl_tb.sv]
// Self-checking bench of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "mic_consts.vh"
module mic_irq_ctrl_tb;
    logic clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_address = 4'h0, port_pins = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic ext_pin = 1'b0, timer_tick = 1'b0, sleep_cmd = 1'b0, ret_cmd = 1'b0;
    logic [7:0] periph_event = 8'h00, vec_cnt;
    logic [12:0] next_pc, pc_load, stack_data;
    logic avs_waitrequest, core_sleep, ret_pulse, vec, push, wake, irq;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, n;
    mic_irq_ctrl i_dut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_irq_pin(ext_pin),
        .upper_port_pins(port_pins), .timer_tick(timer_tick), .periph_event(periph_event),
        .core_sleep(core_sleep), .return_from_irq_instr(ret_pulse), .core_next_pc(next_pc),
        .core_vector_q(vec), .core_pc_load_q(pc_load), .stack_push_q(push),
        .stack_data_q(stack_data), .core_wake_q(wake), .irq_q(irq));
    mic_core_model i_core (.clk(clk), .arst_n(arst_n), .sleep_cmd(sleep_cmd), .ret_cmd(ret_cmd),
        .core_vector_q(vec), .core_pc_load_q(pc_load), .stack_data_q(stack_data),
        .core_sleep(core_sleep), .return_from_irq_instr(ret_pulse), .core_next_pc(next_pc),
        .vec_cnt(vec_cnt));
    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict;
        end
    end
    task check(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task give_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One Avalon access, held until waitrequest is seen low
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {24'h000000, d};
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task rchk(string nm, logic [3:0] a, logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(nm, rd, {24'h000000, e});
    endtask
    // Waits for a wake (w=1) or vector pulse; 60 means none came
    task wait_out(input logic w, output int k);
        k = 0;
        do begin @(posedge clk); k++; end while ((w ? wake : vec) !== 1'b1 && k < 60);
    endtask
    task ticks(int k);
        repeat (k) begin @(posedge clk); timer_tick <= 1'b1; @(posedge clk); timer_tick <= 1'b0; end
    endtask
    task t_reset;
        rchk("ctrl", `MIC_OFS_CTRL, `MIC_CTRL_RST);
        rchk("option", `MIC_OFS_OPTION, `MIC_OPTION_RST);
        rchk("unmapped", 4'h8, 8'h00);
    endtask
    // Flags rise with every enable clear; no vector may follow
    task t_flags;
        ticks(255);
        rchk("timer count", `MIC_OFS_TIMER, 8'hFF);
        rchk("no early flag", `MIC_OFS_CTRL, 8'h00);
        ticks(1);
        rchk("timer flag", `MIC_OFS_CTRL, 8'h04);
        @(posedge clk) periph_event <= 8'h08;
        @(posedge clk) periph_event <= 8'h00;
        rchk("periph flag", `MIC_OFS_PFLAG, 8'h08);
        @(posedge clk) ext_pin <= 1'b1;
        repeat (8) @(posedge clk);
        rchk("pin rise flag", `MIC_OFS_CTRL, 8'h06);
        @(posedge clk) port_pins <= 4'hA;
        repeat (8) @(posedge clk);
        rchk("port flag", `MIC_OFS_CTRL, 8'h07);
        check("no vector", vec_cnt, 8'h00);
        bus(1'b1, `MIC_OFS_CTRL, 8'h00);
        bus(1'b1, `MIC_OFS_OPTION, 8'hBF);
        @(posedge clk) ext_pin <= 1'b0;
        repeat (8) @(posedge clk);
        rchk("pin fall flag", `MIC_OFS_CTRL, 8'h02);
        bus(1'b1, `MIC_OFS_CTRL, 8'h00);
        @(posedge clk) ext_pin <= 1'b1;
        repeat (8) @(posedge clk);
        rchk("rise ignored", `MIC_OFS_CTRL, 8'h00);
    endtask
    // Group gate, entry, return, status and interrupt line
    task t_vector;
        bus(1'b1, `MIC_OFS_PEN, 8'h08);
        bus(1'b1, `MIC_OFS_CTRL, 8'h80);
        wait_out(1'b0, n);
        check("group gate", n, 60);
        bus(1'b1, `MIC_OFS_CTRL, 8'hC0);
        wait_out(1'b0, n);
        check("vector seen", n < 60, 1);
        check("vector pc", pc_load, `MIC_VECTOR);
        check("push with vector", push, 1'b1);
        check("pushed pc", stack_data, 13'h0123);
        rchk("enable cleared", `MIC_OFS_CTRL, 8'h40);
        bus(1'b1, `MIC_OFS_PFLAG, 8'h00);
        @(posedge clk) ret_cmd <= 1'b1;
        @(posedge clk) ret_cmd <= 1'b0;
        rchk("enable restored", `MIC_OFS_CTRL, 8'hC0);
        rchk("status", `MIC_OFS_ISTAT, 8'h05);
        bus(1'b1, `MIC_OFS_IMASK, 8'h01);
        repeat (2) @(posedge clk);
        check("irq high", irq, 1'b1);
        bus(1'b1, `MIC_OFS_ISTAT, 8'h07);
        repeat (2) @(posedge clk);
        check("irq low", irq, 1'b0);
        check("one entry", vec_cnt, 8'h01);
    endtask
    // Pin and port change latency, three to six instruction cycles including sync
    task t_latency;
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, `MIC_OFS_CTRL, i ? 8'h90 : 8'h88);
            @(posedge clk);
            if (i) ext_pin <= 1'b0;
            else port_pins <= 4'h5;
            wait_out(1'b0, n);
            check("latency", n >= 12 && n <= 24, 1);
        end
    endtask
    // Wake from sleep, without and with global enable
    task t_wake;
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, `MIC_OFS_OPTION, 8'hFF);
            @(posedge clk) ext_pin <= 1'b0;
            bus(1'b1, `MIC_OFS_CTRL, i ? 8'h90 : 8'h10);
            @(posedge clk) sleep_cmd <= 1'b1;
            @(posedge clk) sleep_cmd <= 1'b0;
            @(posedge clk) ext_pin <= 1'b1;
            wait_out(1'b1, n);
            check("wake", n < 60, 1);
            wait_out(1'b0, n);
            check("vector after wake", n < 60, i);
            if (i) check("wake vector pc", pc_load, `MIC_VECTOR);
        end
        repeat (30) @(posedge clk);
        check("wake entries", vec_cnt, 8'h04);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        t_reset;
        t_flags;
        t_vector;
        t_latency;
        t_wake;
        give_verdict;
    end
endmodule
`default_nettype wire
